// File: slocfg_device.sv
`timescale 1ns/1ps
`include "slocfg_params.svh"
module slocfg_device #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Link to the host end.
   slocfg_if.device  lnk,
   // Sample source.
   input  wire logic             smp_valid,
   output logic                  smp_ready,
   input  wire logic [WIDTH-1:0] smp_data,
   // Status.
   output logic [31:0]           lane_rate_mbps,
   output logic                  cfg_ok,
   output logic                  pll_mismatch
);
   import slocfg_pkg::*;

   // Only sixteen-bit sample words are carried by the stream.
   if (WIDTH != 16) begin : g_width_check
      $error("WIDTH must be 16");
   end

   // ******************************************************
   // Helper functions
   // ******************************************************
   function automatic logic [31:0] gcd32(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] t;
      x = a;
      y = b;
      for (int i = 0; i < 12; i++) begin
         if (y != 32'd0) begin
            t = x % y;
            x = y;
            y = t;
         end
      end
      return x;
   endfunction

   function automatic logic [7:0] pll_code(input logic [31:0] serial_lane_rate);
      if (serial_lane_rate > `SLOCFG_SLR_TOP_EDGE) return `SLOCFG_PLL_BAND_TOP;
      else if (serial_lane_rate >= `SLOCFG_SLR_MID_EDGE) return `SLOCFG_PLL_BAND_HIGH;
      else if (serial_lane_rate >= `SLOCFG_SLR_LOW_EDGE) return `SLOCFG_PLL_BAND_MID;
      else return `SLOCFG_PLL_BAND_LOW;
   endfunction

   function automatic logic k_ok(input logic [4:0] f, input logic [5:0] k);
      logic [5:0] kmin;
      kmin = 6'd0;
      case (f)
         5'd1:    kmin = 6'd20;
         5'd2:    kmin = 6'd12;
         5'd4:    kmin = 6'd8;
         5'd8:    kmin = 6'd4;
         5'd16:   kmin = 6'd4;
         default: kmin = 6'd63;
      endcase
      return (k >= kmin) && (k <= `SLOCFG_K_MAX) && (k % `SLOCFG_K_STEP == 6'd0);
   endfunction

   // ******************************************************
   // Registers and state
   // ******************************************************
   logic [7:0]    pll_ctrl_reg;
   slocfg_cfg_t   cfg_reg;
   logic [31:0]   fout_reg;
   logic [31:0]   fadc_reg;
   slocfg_state_t state_reg;
   logic [31:0]   slr_reg;
   logic          ok_reg;
   logic [7:0]    rdata_reg;

   // Shape checks computed from the held configuration.
   logic [31:0] slr_calc;
   logic [31:0] num;
   logic [31:0] ratio;
   logic [31:0] lcm_v;
   logic        dcm_ok;
   logic        shape_ok;
   logic        rate_ok;
   logic        mode_ok;

   always_comb begin
      // Lane rate in Mbps; ten line bits per eight data bits.
      num      = `SLOCFG_LINE_BITS * 32'(cfg_reg.convs) * 32'(cfg_reg.word_bits) * fout_reg;
      slr_calc = (cfg_reg.lanes == 5'd0) ? 32'd0 :
                 num / (`SLOCFG_OCTET_BITS * 32'(cfg_reg.lanes));
      // Only the decimation ratios the chip can produce are accepted.
      case (cfg_reg.chip_decimation_ratio)
         5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd8, 5'd12, 5'd16: dcm_ok = 1'b1;
         default: dcm_ok = 1'b0;
      endcase
      // Clock divider limits on lane rate.
      ratio = (slr_calc == 32'd0) ? 32'd0 :
              (32'd20 * 32'(cfg_reg.chip_decimation_ratio) * fout_reg) / slr_calc;
      lcm_v = (ratio == 32'd0) ? 32'd0 :
              (ratio * 32'(cfg_reg.chip_decimation_ratio)) / gcd32(ratio, 32'(cfg_reg.chip_decimation_ratio));
      rate_ok = (32'd2 * slr_calc >= `SLOCFG_SLR_MIN_X2) && (slr_calc <= `SLOCFG_SLR_MAX)
                && (slr_calc <= `SLOCFG_SLR_DIV_CLK * fadc_reg)
                && (lcm_v != 32'd0) && (lcm_v <= `SLOCFG_LCM_MAX);
      // Output rate tied to the sample rate by decimation.
      rate_ok = rate_ok && (fout_reg * 32'(cfg_reg.chip_decimation_ratio) == fadc_reg);
      shape_ok = k_ok(cfg_reg.octets, cfg_reg.frames) && (cfg_reg.hd == 1'b0)
                 && (cfg_reg.lanes == 5'd1 || cfg_reg.lanes == 5'd2 || cfg_reg.lanes == 5'd4);
      // Eight-bit word modes.
      if (cfg_reg.word_bits == `SLOCFG_NP_BITS) begin
         mode_ok = (cfg_reg.res_bits >= `SLOCFG_N_MIN) && (cfg_reg.res_bits <= `SLOCFG_N_MAX)
                   && (cfg_reg.ctrl_bits <= `SLOCFG_CS_MAX)
                   && (cfg_reg.convs == 5'd1 || cfg_reg.convs == 5'd2);
      end else if (cfg_reg.word_bits == `SLOCFG_NP_WIDE) begin
         // Full bandwidth with decimation bypassed.
         if (cfg_reg.chip_decimation_ratio == 5'd1) begin
            mode_ok = cfg_reg.lanes == 5'd4 && cfg_reg.convs == 5'd2 && cfg_reg.octets == 5'd1
                      && cfg_reg.ctrl_bits == 2'd0 && cfg_reg.res_bits == `SLOCFG_FBW_N;
         end else begin
            // Two-DDC complex outputs.
            mode_ok = cfg_reg.convs == 5'd4 && cfg_reg.octets == 5'd4 && cfg_reg.lanes != 5'd1
                      && cfg_reg.ctrl_bits == 2'd0 && cfg_reg.res_bits == `SLOCFG_FBW_N;
         end
      end else begin
         mode_ok = 1'b0;
      end
   end

   // Configuration capture and check sequence.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= SLOCFG_IDLE;
         cfg_reg   <= '0;
         fout_reg  <= '0;
         fadc_reg  <= '0;
         slr_reg   <= '0;
         ok_reg    <= 1'b0;
      end else begin
         case (state_reg)
            SLOCFG_IDLE, SLOCFG_LIVE, SLOCFG_FAULT: begin
               if (lnk.cfg_load) begin
                  cfg_reg   <= lnk.cfg;
                  fout_reg  <= lnk.fout_msps;
                  fadc_reg  <= lnk.fadc_msps;
                  ok_reg    <= 1'b0;
                  state_reg <= SLOCFG_CHECK;
               end
            end
            SLOCFG_CHECK: begin
               slr_reg   <= slr_calc;
               ok_reg    <= dcm_ok && rate_ok && shape_ok && mode_ok;
               state_reg <= (dcm_ok && rate_ok && shape_ok && mode_ok) ? SLOCFG_LIVE
                                                                       : SLOCFG_FAULT;
            end
            default: state_reg <= SLOCFG_IDLE;
         endcase
      end
   end

   // PLL control register; software owns the value.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pll_ctrl_reg <= `SLOCFG_PLL_RESET;
      end else if (lnk.wr_en && lnk.addr == `SLOCFG_PLL_CTRL_ADDR) begin
         pll_ctrl_reg <= lnk.wdata;
      end
   end

   // Register read path, one cycle after the strobe.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdata_reg <= 8'h00;
      end else if (lnk.rd_en) begin
         if (lnk.addr == `SLOCFG_PLL_CTRL_ADDR) rdata_reg <= pll_ctrl_reg;
         else if (lnk.addr == `SLOCFG_STATUS_ADDR) begin
            rdata_reg <= {4'h0, pll_mismatch, ok_reg, state_reg};
         end else if (lnk.addr == `SLOCFG_CFG_ADDR) rdata_reg <= pll_code(slr_reg);
         else rdata_reg <= 8'h00;
      end
   end
   assign lnk.rdata = rdata_reg;

   // Samples only enter the queue once the configuration has been accepted.
   logic smp_ready_i;
   slocfg_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) slocfg_fifo_inst (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .in_valid  (smp_valid && ok_reg),
      .in_ready  (smp_ready_i),
      .in_data   (smp_data),
      .out_valid (lnk.s_valid),
      .out_ready (lnk.s_ready),
      .out_data  (lnk.s_data)
   );
   assign smp_ready = smp_ready_i && ok_reg;

   // Status outputs; mismatch flags a PLL code wrong for the live band.
   assign lane_rate_mbps = slr_reg;
   assign cfg_ok         = ok_reg;
   assign pll_mismatch   = ok_reg && (pll_ctrl_reg != pll_code(slr_reg));
endmodule

// File: slocfg_params.svh
`ifndef SLOCFG_PARAMS_SVH
`define SLOCFG_PARAMS_SVH

// Register map.
`define SLOCFG_PLL_CTRL_ADDR  12'h56e
`define SLOCFG_STATUS_ADDR    12'h570
`define SLOCFG_CFG_ADDR       12'h571

// Serial PLL control codes by lane-rate band.
`define SLOCFG_PLL_BAND_TOP   8'h30
`define SLOCFG_PLL_BAND_HIGH  8'h00
`define SLOCFG_PLL_BAND_MID   8'h10
`define SLOCFG_PLL_BAND_LOW   8'h50
`define SLOCFG_PLL_RESET      8'h00

// Lane-rate limits and band edges in Mbps.
`define SLOCFG_SLR_MIN_X2     32'd3375
`define SLOCFG_SLR_MAX        32'd16000
`define SLOCFG_SLR_TOP_EDGE   32'd13500
`define SLOCFG_SLR_MID_EDGE   32'd6750
`define SLOCFG_SLR_LOW_EDGE   32'd3375
`define SLOCFG_SLR_DIV_CLK    32'd40
`define SLOCFG_LCM_MAX        32'd64
`define SLOCFG_LINE_BITS      32'd10
`define SLOCFG_OCTET_BITS     32'd8

// Transport limits.
`define SLOCFG_K_STEP         6'd4
`define SLOCFG_K_MAX          6'd32
`define SLOCFG_NP_BITS        5'd8
`define SLOCFG_NP_WIDE        5'd16
`define SLOCFG_N_MIN          5'd7
`define SLOCFG_N_MAX          5'd8
`define SLOCFG_CS_MAX         2'd1
`define SLOCFG_FBW_N          5'd14

`endif

// File: slocfg_pkg.sv
package slocfg_pkg;
   // Link configuration record passed between the two ends.
   typedef struct packed {
      logic [4:0]  lanes;
      logic [4:0]  convs;
      logic [4:0]  octets;
      logic [5:0]  frames;
      logic [4:0]  res_bits;
      logic [4:0]  word_bits;
      logic [1:0]  ctrl_bits;
      logic        hd;
      logic [4:0]  chip_decimation_ratio;
   } slocfg_cfg_t;

   typedef enum logic [1:0] {
      SLOCFG_IDLE  = 2'b00,
      SLOCFG_CHECK = 2'b01,
      SLOCFG_LIVE  = 2'b10,
      SLOCFG_FAULT = 2'b11
   } slocfg_state_t;
endpackage

// File: slocfg_if.sv
`timescale 1ns/1ps
interface slocfg_if;
   // Register port.
   logic        wr_en;
   logic        rd_en;
   logic [11:0] addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   // Sample stream.
   logic        s_valid;
   logic        s_ready;
   logic [15:0] s_data;
   // Configuration and the strobe that applies it.
   slocfg_pkg::slocfg_cfg_t cfg;
   logic [31:0] fout_msps;
   logic [31:0] fadc_msps;
   logic        cfg_load;

   modport device (input wr_en, rd_en, addr, wdata, cfg, fout_msps, fadc_msps, cfg_load,
                   s_ready, output rdata, s_valid, s_data);
   modport host   (output wr_en, rd_en, addr, wdata, cfg, fout_msps, fadc_msps, cfg_load,
                   s_ready, input rdata, s_valid, s_data);
endinterface

// File: slocfg_fifo.sv
`timescale 1ns/1ps
module slocfg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Fill side.
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   // Pointer wrap relies on a power-of-two depth of at least two, so refuse anything else.
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("DEPTH must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic             push;
   logic             pop;

   // Full when pointers differ only in the wrap bit.
   assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];

   // Storage write; memory needs no reset.
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   // Pointers.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule

// File: slocfg_host.sv
`timescale 1ns/1ps
`include "slocfg_params.svh"
module slocfg_host (
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Link to the device end.
   slocfg_if.host    lnk,
   // User configuration request.
   input  wire logic                    apply,
   input  wire slocfg_pkg::slocfg_cfg_t user_cfg,
   input  wire logic [31:0]             user_fout,
   input  wire logic [31:0]             user_fadc,
   input  wire logic [31:0]             user_slr,
   output logic                         busy,
   // Received samples.
   output logic                         rx_valid,
   input  wire logic                    rx_ready,
   output logic [15:0]                  rx_data
);
   import slocfg_pkg::*;

   typedef enum logic [1:0] {
      SLOCFGH_IDLE = 2'b00,
      SLOCFGH_PLL  = 2'b01,
      SLOCFGH_LOAD   = 2'b10,
      SLOCFGH_VERIFY = 2'b11
   } slocfgh_state_t;

   slocfgh_state_t st_reg;
   slocfg_cfg_t    cfg_reg;
   logic [31:0]    fout_reg;
   logic [31:0]    fadc_reg;
   logic [7:0]     pll_reg;

   // Band selection for the PLL code.
   function automatic logic [7:0] band(input logic [31:0] serial_lane_rate);
      if (serial_lane_rate > `SLOCFG_SLR_TOP_EDGE) return `SLOCFG_PLL_BAND_TOP;
      else if (serial_lane_rate >= `SLOCFG_SLR_MID_EDGE) return `SLOCFG_PLL_BAND_HIGH;
      else if (serial_lane_rate >= `SLOCFG_SLR_LOW_EDGE) return `SLOCFG_PLL_BAND_MID;
      else return `SLOCFG_PLL_BAND_LOW;
   endfunction

   // Write the PLL code, then hand over the configuration.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_reg   <= SLOCFGH_IDLE;
         cfg_reg  <= '0;
         fout_reg <= '0;
         fadc_reg <= '0;
         pll_reg  <= 8'h00;
      end else begin
         case (st_reg)
            SLOCFGH_IDLE: begin
               if (apply) begin
                  cfg_reg  <= user_cfg;
                  fout_reg <= user_fout;
                  fadc_reg <= user_fadc;
                  pll_reg  <= band(user_slr);
                  st_reg   <= SLOCFGH_PLL;
               end
            end
            SLOCFGH_PLL:  st_reg <= SLOCFGH_LOAD;
            SLOCFGH_LOAD: st_reg <= SLOCFGH_VERIFY;
            // Read the code back so a lost write shows on the link.
            SLOCFGH_VERIFY: st_reg <= SLOCFGH_IDLE;
            default:      st_reg <= SLOCFGH_IDLE;
         endcase
      end
   end

   // Link drive; the lane-rate limits are the user's to respect.
   assign lnk.wr_en     = st_reg == SLOCFGH_PLL;
   assign lnk.rd_en     = st_reg == SLOCFGH_VERIFY;
   assign lnk.addr      = `SLOCFG_PLL_CTRL_ADDR;
   assign lnk.wdata     = pll_reg;
   assign lnk.cfg       = cfg_reg;
   assign lnk.fout_msps = fout_reg;
   assign lnk.fadc_msps = fadc_reg;
   assign lnk.cfg_load  = st_reg == SLOCFGH_LOAD;
   assign busy          = st_reg != SLOCFGH_IDLE;

   // Sample stream passes straight to the user with back-pressure.
   assign rx_valid  = lnk.s_valid;
   assign rx_data   = lnk.s_data;
   assign lnk.s_ready = rx_ready;
endmodule

// File: slocfg_properties.sv
`timescale 1ns/1ps
`include "slocfg_params.svh"
module slocfg_properties (
   // Clock and reset.
   input wire logic                    mclk,
   input wire logic                    sys_rst,
   // Register port.
   input wire logic                    wr_en,
   input wire logic                    rd_en,
   input wire logic [11:0]             addr,
   input wire logic [7:0]              wdata,
   input wire logic [7:0]              rdata,
   // Stream and configuration.
   input wire logic                    s_valid,
   input wire logic                    s_ready,
   input wire logic [15:0]             s_data,
   input wire slocfg_pkg::slocfg_cfg_t cfg,
   input wire logic [31:0]             fout_msps,
   input wire logic [31:0]             fadc_msps,
   input wire logic                    cfg_load
);
   import slocfg_pkg::*;
   // ****************************************
   // Helper logic and properties.
   // ****************************************
   logic [31:0] rate_calc;
   logic [7:0]  band_code;
   logic        band_valid;
   logic        pll_wr;
   logic [7:0]  pll_shadow_reg;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   assign pll_wr = wr_en && addr == `SLOCFG_PLL_CTRL_ADDR;
   // Zero lanes is guarded because it would divide by zero.
   always_comb begin
      rate_calc = (cfg.lanes == 5'h0) ? 32'h0 :
         (32'ha * cfg.convs * cfg.word_bits * fout_msps) / (32'h8 * cfg.lanes);
      band_valid = ({rate_calc, 1'b0} >= 33'hd2f) && rate_calc <= 32'h3e80;
      band_code = (rate_calc > 32'h34bc) ? 8'h30 : (rate_calc >= 32'h1a5e) ? 8'h00 :
         (rate_calc >= 32'hd2f) ? 8'h10 : 8'h50;
   end
   // Shadow of the last code written, to judge read-back.
   always_ff @(posedge mclk) begin
      if (sys_rst) pll_shadow_reg <= 8'h00;
      else if (pll_wr) pll_shadow_reg <= wdata;
   end
   AST_PLL_BAND: assert property (pll_wr && band_valid |-> wdata == band_code)
      else $error("PLL code does not match lane-rate band.");
   AST_PLL_FULLBW: assert property (pll_wr && cfg.lanes == 5'h4 && cfg.convs == 5'h2
      && fout_msps == 32'h514 && cfg.word_bits == 5'h10 |-> wdata == 8'h00)
      else $error("Full-bandwidth PLL code wrong.");
   AST_PLL_DDC: assert property (pll_wr && cfg.convs == 5'h4 && cfg.octets == 5'h4
      && fout_msps == 32'h145 && cfg.lanes inside {5'h2, 5'h4}
      |-> wdata == ((cfg.lanes == 5'h2) ? 8'h00 : 8'h10))
      else $error("DDC PLL code wrong.");
   AST_PLL_READBACK: assert property (rd_en && addr == `SLOCFG_PLL_CTRL_ADDR
      |=> rdata == pll_shadow_reg) else $error("PLL read-back differs.");
   AST_UNMAPPED_ZERO: assert property (rd_en && !(addr inside {12'h56e, 12'h570,
      12'h571}) |=> rdata == 8'h00) else $error("Unmapped read not zero.");
   AST_LOAD_AFTER_PLL: assert property (cfg_load |-> $past(pll_wr))
      else $error("Load not preceded by PLL write.");
   AST_LOAD_SPACING: assert property (cfg_load |=> !cfg_load)
      else $error("Loads too close.");
   AST_STREAM_HOLD: assert property (s_valid && !s_ready |=> s_valid && $stable(s_data))
      else $error("Stream word dropped while stalled.");
   COV_LOAD: cover property (cfg_load);
   COV_PLL: cover property (pll_wr);
   COV_STREAM: cover property (s_valid && s_ready);
endmodule

// File: slocfg_tb_top.sv
`timescale 1ns/1ps
module slocfg_tb_top;
   import slocfg_pkg::*;
   // ****************************************
   // Bench signals and instances.
   // ****************************************
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        apply = 1'b0;
   slocfg_cfg_t user_cfg = '0;
   logic [31:0] user_fout = '0;
   logic [31:0] user_fadc = '0;
   logic [31:0] user_slr = '0;
   logic        busy, rx_valid, smp_ready, cfg_ok, pll_mismatch;
   logic        rx_ready = 1'b0;
   logic        smp_valid = 1'b0;
   logic [15:0] smp_data = '0;
   logic [15:0] rx_data;
   logic [31:0] lane_rate_mbps;
   int          failures = 0;
   int          check_count = 0;
   // Eight-bit base mode: L1 M1 F1 K20 N8 CS1, decimation 2.
   localparam slocfg_cfg_t EB = '{5'h1, 5'h1, 5'h1, 6'h14, 5'h8, 5'h8, 2'h1, 1'b0, 5'h2};
   slocfg_if lnk_if ();
   slocfg_device #(.WIDTH(16), .DEPTH(16)) slocfg_device_inst (.mclk(mclk),
      .sys_rst(sys_rst), .lnk(lnk_if), .smp_valid(smp_valid), .smp_ready(smp_ready),
      .smp_data(smp_data), .lane_rate_mbps(lane_rate_mbps), .cfg_ok(cfg_ok),
      .pll_mismatch(pll_mismatch));
   slocfg_host slocfg_host_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk_if),
      .apply(apply), .user_cfg(user_cfg), .user_fout(user_fout), .user_fadc(user_fadc),
      .user_slr(user_slr), .busy(busy), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data));
   slocfg_properties slocfg_properties_inst (.mclk(mclk), .sys_rst(sys_rst),
      .wr_en(lnk_if.wr_en), .rd_en(lnk_if.rd_en), .addr(lnk_if.addr),
      .wdata(lnk_if.wdata), .rdata(lnk_if.rdata), .s_valid(lnk_if.s_valid),
      .s_ready(lnk_if.s_ready), .s_data(lnk_if.s_data), .cfg(lnk_if.cfg),
      .fout_msps(lnk_if.fout_msps), .fadc_msps(lnk_if.fadc_msps), .cfg_load(lnk_if.cfg_load));
   // Half period of 50 ns gives 10 MHz.
   always #50 mclk = ~mclk;
   // Compare with case equality so unknowns never pass.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   // Print counts and verdict, then stop.
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Pulse apply, wait out busy with a bound, then let the load settle.
   task automatic run_cfg(input slocfg_cfg_t c, input logic [31:0] fo, fa, sl);
      int n;
      @(negedge mclk);
      user_cfg = c;
      user_fout = fo;
      user_fadc = fa;
      user_slr = sl;
      apply = 1'b1;
      @(negedge mclk);
      apply = 1'b0;
      for (n = 0; n < 50 && busy !== 1'b0; n++) @(negedge mclk);
      chk(32'(busy), 32'h0, "host idle");
      repeat (6) @(negedge mclk);
   endtask
   task automatic expect_cfg(input logic ok, input logic [31:0] rate);
      chk(32'(cfg_ok), 32'(ok), "accept");
      chk(lane_rate_mbps, rate, "lane rate");
      chk(32'(pll_mismatch), 32'h0, "pll code");
   endtask
   task automatic t_full_bw();
      run_cfg('{5'h4, 5'h2, 5'h1, 6'h20, 5'he, 5'h10, 2'h0, 1'b0, 5'h1}, 32'h514, 32'h514,
         32'h32c8);
      expect_cfg(1'b1, 32'h32c8);
      chk(32'(lnk_if.rdata), 32'h0, "full readback");
   endtask
   task automatic t_ddc();
      run_cfg('{5'h2, 5'h4, 5'h4, 6'h20, 5'he, 5'h10, 2'h0, 1'b0, 5'h4}, 32'h145, 32'h514,
         32'h32c8);
      expect_cfg(1'b1, 32'h32c8);
      chk(32'(lnk_if.rdata), 32'h0, "ddc two-lane readback");
      run_cfg('{5'h4, 5'h4, 5'h4, 6'h20, 5'he, 5'h10, 2'h0, 1'b0, 5'h4}, 32'h145, 32'h514,
         32'h1964);
      expect_cfg(1'b1, 32'h1964);
      chk(32'(lnk_if.rdata), 32'h10, "ddc four-lane readback");
   endtask
   task automatic t_bands();
      run_cfg('{5'h1, 5'h2, 5'h2, 6'h0c, 5'h8, 5'h8, 2'h0, 1'b0, 5'h1}, 32'h2ee, 32'h2ee,
         32'h3a98);
      chk(lane_rate_mbps, 32'h3a98, "top rate");
      chk(32'(pll_mismatch), 32'h0, "top code");
      chk(32'(cfg_ok), 32'h1, "top accept");
      chk(32'(lnk_if.rdata), 32'h30, "top readback");
      run_cfg(EB, 32'hfa, 32'h1f4, 32'h9c4);
      expect_cfg(1'b1, 32'h9c4);
      chk(32'(lnk_if.rdata), 32'h50, "low readback");
   endtask
   // Fill with the far side stalled until refused, then drain in order.
   task automatic t_stream();
      int sent, got, n;
      logic full;
      sent = 0;
      got = 0;
      full = 1'b0;
      for (n = 0; n < 40 && !full; n++) begin
         @(negedge mclk);
         smp_valid = 1'b1;
         smp_data = 16'ha500 + 16'(sent);
         #10;
         if (smp_ready === 1'b1) sent++;
         else full = 1'b1;
      end
      @(negedge mclk);
      smp_valid = 1'b0;
      chk(32'(full), 32'h1, "fifo refuses when full");
      chk(32'(sent), 32'h10, "fifo depth");
      rx_ready = 1'b1;
      // Look at the head word before the next rising edge pops it.
      for (n = 0; n < 200 && got < sent; n++) begin
         if (rx_valid === 1'b1) begin
            chk(32'(rx_data), 32'(16'ha500 + 16'(got)), "word order");
            got++;
         end
         @(negedge mclk);
      end
      @(negedge mclk);
      chk(32'(got), 32'(sent), "word count");
      chk(32'(rx_valid), 32'h0, "drained");
   endtask
   // Each faulty variant must be refused; the last one must also block samples.
   task automatic t_rejects();
      slocfg_cfg_t c;
      c = EB;
      c.frames = 6'h10;
      run_cfg(c, 32'hfa, 32'h1f4, 32'h9c4);
      chk(32'(cfg_ok), 32'h0, "bad frames");
      c = EB;
      c.chip_decimation_ratio = 5'h7;
      run_cfg(c, 32'hfa, 32'h6d6, 32'h9c4);
      chk(32'(cfg_ok), 32'h0, "bad decimation");
      run_cfg(EB, 32'hfa, 32'h258, 32'h9c4);
      chk(32'(cfg_ok), 32'h0, "rate mismatch");
      c = EB;
      c.res_bits = 5'h9;
      run_cfg(c, 32'hfa, 32'h1f4, 32'h9c4);
      chk(32'(cfg_ok), 32'h0, "resolution");
      c = EB;
      c.hd = 1'b1;
      run_cfg(c, 32'hfa, 32'h1f4, 32'h9c4);
      chk(32'(cfg_ok), 32'h0, "high density");
      run_cfg(EB, 32'h64, 32'hc8, 32'h3e8);
      chk(32'(cfg_ok), 32'h0, "lane rate low");
      chk(32'(smp_ready), 32'h0, "samples blocked");
   endtask
   // Watchdog sized well past the expected few hundred cycles.
   initial begin
      #500000;
      failures++;
      test_done();
   end
   initial begin
      repeat (20) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      chk(32'(smp_ready), 32'h0, "blocked after reset");
      t_full_bw();
      t_ddc();
      t_bands();
      t_stream();
      t_rejects();
      test_done();
   end
endmodule
